// >>> pss_summary.sv
`timescale 1ns/1ps
module pss_summary
   import pss_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pair_swap_auto,
   input wire logic rx_error_event,
   input wire logic polarity_inverted_event,
   input wire logic false_carrier_event,
   input wire logic raw_signal_detect,
   input wire logic descrambler_lock,
   input wire logic page_received_event,
   input wire logic internal_interrupt_event,
   input wire logic remote_fault_event,
   output logic irq
);
   default clocking pss_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========================================
   // pin synchronisers
   logic [8:0] sync1;
   logic [8:0] sync2;
   logic [8:0] raw_in;
   assign raw_in = {pair_swap_auto, rx_error_event, polarity_inverted_event,
      false_carrier_event, raw_signal_detect, descrambler_lock,
      page_received_event, internal_interrupt_event, remote_fault_event};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end
   logic s_swap, s_rxe, s_pol, s_fc, s_sd, s_lock, s_page, s_int, s_rf;
   assign {s_swap, s_rxe, s_pol, s_fc, s_sd, s_lock, s_page, s_int, s_rf} =
      sync2;

   // ==========================================
   // axi4-lite slave
   logic [7:0] aw_q;
   logic aw_have;
   logic [31:0] w_q;
   logic w_have;
   logic w_strb0;
   logic do_write;
   logic do_read;
   logic [2:0] control;
   logic [PSS_NIRQ-1:0] irq_status;
   logic [PSS_NIRQ-1:0] irq_enable;
   logic [PSS_NIRQ-1:0] irq_clear;
   logic [7:0] mgmt_read_idx;
   logic mgmt_read;
   logic [15:0] summary;

   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready = !w_have && !s_axi_bvalid;
   assign do_write = aw_have && w_have && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_read = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         aw_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have <= 1'b1;
         aw_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_have <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have <= 1'b0;
         w_q <= 32'h00000000;
         w_strb0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have <= 1'b1;
         w_q <= s_axi_wdata;
         // every field sits in the low byte, so only lane 0 gates a write
         w_strb0 <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_have <= 1'b0;
      end
   end

   // summary address is read-only; writes there are ignored with okay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (aw_q == PSS_IRQ_ENABLE_ADDR || aw_q == PSS_IRQ_CLEAR_ADDR ||
             aw_q == PSS_CONTROL_ADDR || aw_q == PSS_READ_STROBE_ADDR ||
             aw_q == PSS_SUMMARY_ADDR || aw_q == PSS_IRQ_STATUS_ADDR) begin
            s_axi_bresp <= 2'h0;
         end else begin
            s_axi_bresp <= 2'h2;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic wr_hit(input logic [7:0] a);
      return do_write && (aw_q == a) && w_strb0;
   endfunction : wr_hit

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control <= PSS_CONTROL_RESET;
         irq_enable <= '0;
      end else if (wr_hit(PSS_CONTROL_ADDR)) begin
         control <= w_q[2:0];
      end else if (wr_hit(PSS_IRQ_ENABLE_ADDR)) begin
         irq_enable <= w_q[PSS_NIRQ-1:0];
      end
   end

   assign irq_clear = wr_hit(PSS_IRQ_CLEAR_ADDR) ? w_q[PSS_NIRQ-1:0] : '0;
   // management-side reads of other registers arrive as index writes
   assign mgmt_read = wr_hit(PSS_READ_STROBE_ADDR);
   assign mgmt_read_idx = w_q[7:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         if (s_axi_araddr == PSS_SUMMARY_ADDR) begin
            s_axi_rdata <= {16'h0000, summary};
         end else if (s_axi_araddr == PSS_IRQ_STATUS_ADDR) begin
            s_axi_rdata <= {27'h0000000, irq_status};
         end else if (s_axi_araddr == PSS_IRQ_ENABLE_ADDR) begin
            s_axi_rdata <= {27'h0000000, irq_enable};
         end else if (s_axi_araddr == PSS_CONTROL_ADDR) begin
            s_axi_rdata <= {29'h0000000, control};
         end else if (s_axi_araddr == PSS_IRQ_CLEAR_ADDR ||
                      s_axi_araddr == PSS_READ_STROBE_ADDR) begin
            s_axi_rdata <= 32'h00000000;
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================
   // summary bits
   logic clr_rx, clr_fc, clr_pol, clr_page, clr_int, clr_rf, sum_rd;
   assign clr_rx = mgmt_read && mgmt_read_idx == PSS_IDX_RX_ERROR;
   assign clr_fc = mgmt_read && mgmt_read_idx == PSS_IDX_FALSE_CARRIER;
   assign clr_pol = mgmt_read && mgmt_read_idx == PSS_IDX_TEN_MBPS;
   assign clr_page = mgmt_read && mgmt_read_idx == PSS_IDX_AN_EXPANSION;
   assign clr_int = mgmt_read && mgmt_read_idx == PSS_IDX_INT_STATUS;
   assign clr_rf = mgmt_read && mgmt_read_idx == PSS_IDX_BASIC_STATUS;
   assign sum_rd = do_read && s_axi_araddr == PSS_SUMMARY_ADDR;

   logic crossover_state, rx_err, pol, fcs, sd_lat, lock_lat, page, intp, rf;
   logic sd_qual;
   // force wins over auto; with auto alone the bit follows the algorithm
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crossover_state <= 1'b0;
      end else if (control[PSS_C_XFORCE]) begin
         crossover_state <= 1'b1;
      end else if (control[PSS_C_XAUTO]) begin
         crossover_state <= s_swap;
      end else begin
         crossover_state <= 1'b0;
      end
   end

   // set wins over clear in every latch below
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_err <= 1'b0;
         fcs <= 1'b0;
         pol <= 1'b0;
         page <= 1'b0;
         intp <= 1'b0;
         rf <= 1'b0;
      end else begin
         rx_err <= s_rxe | (rx_err & !clr_rx);
         fcs <= s_fc | (fcs & !clr_fc);
         pol <= s_pol | (pol & !clr_pol);
         page <= s_page | (page & !clr_page);
         intp <= s_int | (intp & !clr_int);
         rf <= s_rf | (rf & !clr_rf);
      end
   end

   assign sd_qual = control[PSS_C_SDQUAL] ? (s_sd & s_lock) : s_sd;
   // latched low: a drop holds zero until the summary is read, then resamples
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sd_lat <= 1'b0;
         lock_lat <= 1'b0;
      end else if (sum_rd) begin
         sd_lat <= sd_qual;
         lock_lat <= s_lock;
      end else begin
         sd_lat <= sd_lat & sd_qual;
         lock_lat <= lock_lat & s_lock;
      end
   end

   always_comb begin
      summary = PSS_SUMMARY_RESET;
      summary[PSS_B_RSVD] = 1'b0;
      summary[PSS_B_XOVER] = crossover_state;
      summary[PSS_B_RXERR] = rx_err;
      summary[PSS_B_POL] = pol;
      summary[PSS_B_FCS] = fcs;
      summary[PSS_B_SD] = sd_lat;
      summary[PSS_B_LOCK] = lock_lat;
      summary[PSS_B_PAGE] = page;
      summary[PSS_B_INT] = intp;
      summary[PSS_B_RF] = rf;
   end

   // ==========================================
   // interrupt status: rx error, false carrier, remote fault, page, int
   logic [PSS_NIRQ-1:0] ev;
   assign ev = {s_int, s_page, s_rf, s_fc, s_rxe};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= ev | (irq_status & ~irq_clear);
      end
   end
   assign irq = |(irq_status & irq_enable);

   // ==========================================
   // checks
   rsvd_zero_a: assert property (
      s_axi_rvalid && $past(sum_rd) |-> !s_axi_rdata[15])
      else $error("reserved summary bit read nonzero");
   rxerr_set_a: assert property (
      s_rxe |=> rx_err)
      else $error("rx error event not latched");
   rxerr_hold_a: assert property (
      rx_err && !clr_rx |=> rx_err)
      else $error("rx error latch dropped without counter read");
   pol_keep_a: assert property (
      pol && !clr_pol |=> pol)
      else $error("polarity bit dropped without its register read");
   fcs_hold_a: assert property (
      fcs && !clr_fc |=> fcs)
      else $error("false carrier latch dropped early");
   sd_qual_a: assert property (
      control[PSS_C_SDQUAL] && !s_lock |=> !sd_lat)
      else $error("qualified signal detect high without lock");
   lock_low_a: assert property (
      !lock_lat && !sum_rd |=> !lock_lat)
      else $error("lock latch rose without summary read");
   page_keep_a: assert property (
      page && sum_rd && !clr_page |=> page)
      else $error("page bit cleared by summary read");
   int_clear_a: assert property (
      clr_int && !s_int |=> !intp)
      else $error("pending interrupt not cleared");
   rf_clear_a: assert property (
      clr_rf && !s_rf |=> !rf)
      else $error("remote fault not cleared");
   force_swap_a: assert property (
      control[PSS_C_XFORCE] ##1 control[PSS_C_XFORCE] |-> crossover_state)
      else $error("forced crossover not reported");
   xover_auto_a: assert property (
      control[PSS_C_XAUTO] && !control[PSS_C_XFORCE] |=>
         crossover_state == $past(s_swap))
      else $error("auto crossover not following the swap state");
   // steps of a summary read: taken on one edge, answered on the next
   sequence sum_read_s;
      sum_rd ##1 s_axi_rvalid;
   endsequence
   sum_word_a: assert property (
      sum_read_s |-> s_axi_rdata == {16'h0000, $past(summary)})
      else $error("summary read returned the wrong word");
endmodule : pss_summary

// >>> pss_pkg.sv
package pss_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] PSS_SUMMARY_ADDR = 8'h40;
   localparam logic [7:0] PSS_IRQ_STATUS_ADDR = 8'h00;
   localparam logic [7:0] PSS_IRQ_ENABLE_ADDR = 8'h04;
   localparam logic [7:0] PSS_IRQ_CLEAR_ADDR = 8'h08;
   localparam logic [7:0] PSS_CONTROL_ADDR = 8'h0C;
   localparam logic [7:0] PSS_READ_STROBE_ADDR = 8'h10;
   // management register indices; reads of all but PSS_IDX_SUMMARY clear summary bits
   localparam logic [7:0] PSS_IDX_SUMMARY = 8'h10;
   localparam logic [7:0] PSS_IDX_BASIC_STATUS = 8'h01;
   localparam logic [7:0] PSS_IDX_AN_EXPANSION = 8'h06;
   localparam logic [7:0] PSS_IDX_INT_STATUS = 8'h12;
   localparam logic [7:0] PSS_IDX_FALSE_CARRIER = 8'h14;
   localparam logic [7:0] PSS_IDX_RX_ERROR = 8'h15;
   localparam logic [7:0] PSS_IDX_TEN_MBPS = 8'h1A;
   // summary field positions
   localparam int PSS_B_RSVD = 15;
   localparam int PSS_B_XOVER = 14;
   localparam int PSS_B_RXERR = 13;
   localparam int PSS_B_POL = 12;
   localparam int PSS_B_FCS = 11;
   localparam int PSS_B_SD = 10;
   localparam int PSS_B_LOCK = 9;
   localparam int PSS_B_PAGE = 8;
   localparam int PSS_B_INT = 7;
   localparam int PSS_B_RF = 6;
   // control field positions
   localparam int PSS_C_XAUTO = 0;
   localparam int PSS_C_XFORCE = 1;
   localparam int PSS_C_SDQUAL = 2;
   localparam logic [2:0] PSS_CONTROL_RESET = 3'h1;
   localparam int PSS_NIRQ = 5;
   localparam logic [15:0] PSS_SUMMARY_RESET = 16'h0000;
endpackage : pss_pkg

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb;
   import pss_pkg::*;
   // ==========================================
   // signals
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, swap, raw_sd, lock, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rr, br;
   logic [5:0] ev;
   int err_count, checked, i;
   // event lines in order rx error, polarity, false carrier, page, irq, fault
   localparam int EB[6] = '{13, 12, 11, 8, 7, 6};
   localparam logic [7:0] EI[6] = '{8'h15, 8'h1A, 8'h14, 8'h06, 8'h12, 8'h01};
   pss_summary u_pss_summary (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pair_swap_auto(swap),
      .rx_error_event(ev[0]), .polarity_inverted_event(ev[1]),
      .false_carrier_event(ev[2]), .raw_signal_detect(raw_sd),
      .descrambler_lock(lock), .page_received_event(ev[3]),
      .internal_interrupt_event(ev[4]), .remote_fault_event(ev[5]),
      .irq(irq));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // ==========================================
   // closing report
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   // ==========================================
   // bus tasks: each handshake is judged at the rising edge where it
   // happens, and the channel is released just after that edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic db;
      db = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 50 && !db; n++) begin
         @(posedge aclk);
         if (awvalid && awready) begin awvalid <= 1'b0; end
         if (wvalid && wready) begin wvalid <= 1'b0; end
         if (bvalid && bready) begin
            br = bresp; bready <= 1'b0; db = 1;
         end
      end
      if (!db) begin err_count++; end_of_test(); end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      int n;
      logic dr;
      dr = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50 && !dr; n++) begin
         @(posedge aclk);
         if (arvalid && arready) begin arvalid <= 1'b0; end
         if (rvalid && rready) begin
            rd = rdata; rr = rresp; rready <= 1'b0; dr = 1;
         end
      end
      if (!dr) begin err_count++; end_of_test(); end
   endtask : axi_rd
   task automatic pause;
      repeat (6) @(posedge aclk);
   endtask : pause
   // ==========================================
   // main sequence
   initial begin
      err_count = 0; checked = 0;
      aresetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
      rready = 0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
      swap = 1'b0; raw_sd = 1'b1; lock = 1'b1; ev = 6'h00;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // let the pin synchronisers fill before the first summary read
      pause();
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd, 32'h0000_0000)
      axi_rd(PSS_CONTROL_ADDR); `CHK(rd[2:0], PSS_CONTROL_RESET)
      axi_wr(PSS_SUMMARY_ADDR, 32'hFFFF_FFFF); `CHK(br, 2'h0)
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[31:15], 17'h00000)
      `CHK(rd[13:11], 3'h0)
      `CHK(rd[10:9], 2'h3)
      // crossover: auto follows the algorithm, force overrides
      swap <= 1'b1; pause();
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[14], 1'b1)
      swap <= 1'b0; pause();
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[14], 1'b0)
      axi_wr(PSS_CONTROL_ADDR, 32'h0000_0002);
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[14], 1'b1)
      axi_wr(PSS_CONTROL_ADDR, 32'h0000_0000); swap <= 1'b1; pause();
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[14], 1'b0)
      // signal detect and lock, latched low until a summary read
      lock <= 1'b0; pause();
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[10:9], 2'h2)
      axi_wr(PSS_CONTROL_ADDR, 32'h0000_0005); pause();
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[10:9], 2'h0)
      lock <= 1'b1; pause();
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[10:9], 2'h0)
      axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[10:9], 2'h3)
      // each event latches and only its own register read clears it
      for (i = 0; i < 6; i++) begin
         @(posedge aclk); ev[i] <= 1'b1;
         repeat (3) @(posedge aclk); ev[i] <= 1'b0; pause();
         axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[EB[i]], 1'b1)
         axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[EB[i]], 1'b1)
         axi_wr(PSS_READ_STROBE_ADDR, {24'h0, EI[i]});
         axi_rd(PSS_SUMMARY_ADDR); `CHK(rd[EB[i]], 1'b0)
      end
      // interrupt: enable, raise, clear, then masked raise
      axi_wr(PSS_IRQ_CLEAR_ADDR, 32'h0000_001F);
      axi_wr(PSS_IRQ_ENABLE_ADDR, 32'h0000_001F);
      @(posedge aclk); ev[0] <= 1'b1;
      repeat (3) @(posedge aclk); ev[0] <= 1'b0; pause();
      `CHK(irq, 1'b1)
      axi_wr(PSS_IRQ_CLEAR_ADDR, 32'h0000_001F); pause(); `CHK(irq, 1'b0)
      axi_wr(PSS_IRQ_ENABLE_ADDR, 32'h0000_0000);
      @(posedge aclk); ev[2] <= 1'b1;
      repeat (3) @(posedge aclk); ev[2] <= 1'b0; pause();
      `CHK(irq, 1'b0)
      axi_wr(PSS_IRQ_ENABLE_ADDR, 32'h0000_001F); pause(); `CHK(irq, 1'b1)
      // unmapped address answers with an error and zero data
      axi_rd(8'h20); `CHK(rr, 2'h2)
      `CHK(rd, 32'h0000_0000)
      axi_wr(8'h20, 32'h0000_0000); `CHK(br, 2'h2)
      end_of_test();
   end
endmodule : tb
